// *** design/usp_port.sv ***
`timescale 1ns/10ps
module usp_port
    import usp_pkg::*;
(
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    // configuration
    input  wire usp_pkg::usp_cfg_s   cfg_in,
    // transmit request
    input  wire usp_pkg::usp_char_s  tx_char_in,
    output logic                     tx_ready_out,
    // receive queue read
    input  wire logic                rx_pop_in,
    output usp_pkg::usp_char_s       rx_char_out,
    output usp_pkg::usp_status_s     status_out,
    // serial pins
    output logic                     serial_tx_line_out,
    input  wire logic                serial_rx_line_in,
    input  wire logic                send_permit_in,
    output logic                     send_request_out
);
    import usp_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA  = 4'b0100,
        TX_STOP  = 4'b1000
    } usp_tx_e;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } usp_rx_e;

    typedef struct packed {
        logic        clk_run;
        logic        rx_prev;
        logic [15:0] div_cnt;
        logic [3:0]  os_cnt;
        logic        tick_phase;
        usp_tx_e     tx_st;
        logic [3:0]  tx_os;
        logic [3:0]  tx_bit;
        usp_byte_t   tx_sh;
        logic        tx_line;
        logic        tx_ready;
        logic        tx_busy;
        usp_rx_e     rx_st;
        logic [3:0]  rx_os;
        logic [3:0]  rx_bit;
        usp_byte_t   rx_sh;
        logic [USP_PTR_W-1:0] wr_ptr;
        logic [USP_PTR_W-1:0] rd_ptr;
        logic [USP_CNT_W-1:0] fill;
        usp_char_s   rd_char;
        logic        rts;
        logic        frame_err;
        logic        overrun;
    } usp_state_s;

    usp_state_s st_q;
    usp_state_s st_d;
    usp_byte_t  queue_mem [USP_QUEUE_DEPTH];
    logic       rx_lvl;
    logic       cts_lvl;
    logic       os_tick;
    logic       bit_fall;
    logic       push;

    // ****************************************
    // pin synchronisers
    // ****************************************
    usp_sync #(.RESET_VAL(1'b1)) u_rx_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (serial_rx_line_in),
        .level_out  (rx_lvl)
    );

    usp_sync #(.RESET_VAL(1'b0)) u_cts_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (send_permit_in),
        .level_out  (cts_lvl)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_d       = st_q;
        os_tick    = 1'b0;
        bit_fall   = 1'b0;
        push       = 1'b0;
        st_d.rx_prev = rx_lvl;
        // power-down gates the serial clock; rx edge wakes it
        if (cfg_in.power_down && !st_q.clk_run && (rx_lvl != st_q.rx_prev))
        begin
            st_d.clk_run = 1'b1;
        end
        else if (cfg_in.power_down && st_q.tx_st == TX_IDLE && st_q.rx_st == RX_IDLE)
        begin
            st_d.clk_run = st_q.clk_run && !rx_lvl;
        end
        else if (!cfg_in.power_down)
        begin
            st_d.clk_run = 1'b1;
        end
        if (st_q.clk_run)
        begin
            if (st_q.div_cnt >= cfg_in.divisor)
            begin
                st_d.div_cnt = 16'h0000;
                os_tick      = 1'b1;
            end
            else
            begin
                st_d.div_cnt = st_q.div_cnt + 16'h0001;
            end
        end
        // serial clock falls at the bit boundary
        if (os_tick)
        begin
            st_d.tx_os = st_q.tx_os + 4'h1;
            bit_fall   = (st_q.tx_os == 4'(USP_OVERSAMPLE - 1));
        end
        // transmitter
        unique case (st_q.tx_st)
            TX_IDLE:
            begin
                st_d.tx_line  = 1'b1;
                st_d.tx_ready = cfg_in.tx_enable && !cfg_in.loopback;
                if (tx_char_in.valid && st_q.tx_ready && (cts_lvl || !cfg_in.cts_enable))
                begin
                    st_d.tx_sh    = tx_char_in.data;
                    st_d.tx_ready = 1'b0;
                    st_d.tx_st    = TX_START;
                end
            end
            TX_START:
            begin
                if (bit_fall)
                begin
                    st_d.tx_line = 1'b0;
                    st_d.tx_bit  = 4'h0;
                    st_d.tx_st   = TX_DATA;
                end
            end
            TX_DATA:
            begin
                if (bit_fall)
                begin
                    st_d.tx_line = st_q.tx_sh[0];
                    st_d.tx_sh   = st_q.tx_sh >> 1;
                    st_d.tx_bit  = st_q.tx_bit + 4'h1;
                    if (st_q.tx_bit == 4'(USP_DATA_BITS))
                    begin
                        st_d.tx_line = 1'b1;
                        st_d.tx_bit  = 4'h0;
                        st_d.tx_st   = TX_STOP;
                    end
                end
            end
            TX_STOP:
            begin
                if (bit_fall)
                begin
                    st_d.tx_bit = st_q.tx_bit + 4'h1;
                    if (st_q.tx_bit >= {3'h0, cfg_in.two_stop})
                    begin
                        st_d.tx_st = TX_IDLE;
                    end
                end
            end
        endcase
        st_d.tx_busy = (st_d.tx_st != TX_IDLE);
        // receiver, sampled mid-bit
        unique case (st_q.rx_st)
            RX_IDLE:
            begin
                if (cfg_in.rx_enable && !rx_lvl && st_q.clk_run)
                begin
                    st_d.rx_os = 4'h0;
                    st_d.rx_st = RX_START;
                end
            end
            RX_START:
            begin
                if (os_tick)
                begin
                    st_d.rx_os = st_q.rx_os + 4'h1;
                    if (st_q.rx_os == 4'(USP_HALF_OS - 1))
                    begin
                        st_d.rx_os  = 4'h0;
                        st_d.rx_bit = 4'h0;
                        st_d.rx_st  = rx_lvl ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA:
            begin
                if (os_tick)
                begin
                    st_d.rx_os = st_q.rx_os + 4'h1;
                    if (st_q.rx_os == 4'(USP_OVERSAMPLE - 1))
                    begin
                        st_d.rx_sh  = {rx_lvl, st_q.rx_sh[USP_DATA_BITS-1:1]};
                        st_d.rx_bit = st_q.rx_bit + 4'h1;
                        if (st_q.rx_bit == 4'(USP_DATA_BITS - 1))
                        begin
                            st_d.rx_st = RX_STOP;
                        end
                    end
                end
            end
            RX_STOP:
            begin
                if (os_tick)
                begin
                    st_d.rx_os = st_q.rx_os + 4'h1;
                    if (st_q.rx_os == 4'(USP_OVERSAMPLE - 1))
                    begin
                        st_d.frame_err = st_q.frame_err || !rx_lvl;
                        push           = rx_lvl;
                        st_d.rx_st     = RX_IDLE;
                    end
                end
            end
        endcase
        // receive queue; overrun is set here, frame_err in the receiver, and both sticky flags clear only on reset
        st_d.rd_char.valid = 1'b0;
        if (rx_pop_in && st_q.fill != '0)
        begin
            st_d.rd_char.valid = 1'b1;
            st_d.rd_char.data  = queue_mem[st_q.rd_ptr];
            st_d.rd_ptr        = st_q.rd_ptr + 1'b1;
        end
        if (push && st_q.fill == USP_CNT_W'(USP_QUEUE_DEPTH))
        begin
            st_d.overrun = 1'b1;
            push         = 1'b0;
        end
        if (push)
        begin
            st_d.wr_ptr = st_q.wr_ptr + 1'b1;
        end
        st_d.fill = st_q.fill + USP_CNT_W'(push) - USP_CNT_W'(st_d.rd_char.valid);
        // request-to-send, with hysteresis on fill level
        if (cfg_in.rts_auto)
        begin
            if (st_d.fill >= cfg_in.rts_high)
            begin
                st_d.rts = 1'b0;
            end
            else if (st_d.fill <= cfg_in.rts_low)
            begin
                st_d.rts = cfg_in.rx_enable;
            end
        end
        else
        begin
            st_d.rts = cfg_in.rts_manual || (cfg_in.rx_enable && st_q.rx_st != RX_IDLE);
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            st_q          <= '0;
            st_q.clk_run  <= 1'b1;
            st_q.rx_prev  <= 1'b1;
            st_q.tx_st    <= TX_IDLE;
            st_q.rx_st    <= RX_IDLE;
            st_q.tx_line  <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            queue_mem[st_q.wr_ptr] <= st_q.rx_sh;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign serial_tx_line_out     = st_q.tx_line;
    assign send_request_out       = st_q.rts;
    assign tx_ready_out           = st_q.tx_ready;
    assign rx_char_out            = st_q.rd_char;
    assign status_out.frame_err   = st_q.frame_err;
    assign status_out.overrun     = st_q.overrun;
    assign status_out.clk_running = st_q.clk_run;
    assign status_out.tx_busy     = st_q.tx_busy;
    assign status_out.fill        = st_q.fill;
endmodule : usp_port

// *** design/usp_pkg.sv ***
// What this block does
// - transmit line stays high when disabled, idle, or in local loopback.
// - characters leave lsb first, line changes on falling serial clock edge.
// - received characters arrive and are assembled lsb first.
// - stopped port clock restarts on any receive line transition.
// - send request output driven from rts_manual or receive activity, optionally from receive queue fill.
package usp_pkg;
    localparam int          USP_DATA_BITS   = 8;
    localparam int          USP_OVERSAMPLE  = 16;
    localparam int          USP_HALF_OS     = USP_OVERSAMPLE / 2;
    localparam int          USP_QUEUE_DEPTH = 8;
    localparam int          USP_PTR_W       = $clog2(USP_QUEUE_DEPTH);
    localparam int          USP_CNT_W       = USP_PTR_W + 1;
    localparam logic [15:0] USP_DIV_RESET   = 16'h001b;
    localparam logic [USP_CNT_W-1:0] USP_RTS_HIGH_RESET = 4'h6;
    localparam logic [USP_CNT_W-1:0] USP_RTS_LOW_RESET  = 4'h2;

    typedef logic [USP_DATA_BITS-1:0] usp_byte_t;

    typedef struct packed {
        logic      tx_enable;
        logic      rx_enable;
        logic      loopback;
        logic      power_down;
        logic      rts_auto;
        logic      rts_manual;
        logic      cts_enable;
        logic      two_stop;
        logic [15:0] divisor;
        logic [USP_CNT_W-1:0] rts_high;
        logic [USP_CNT_W-1:0] rts_low;
    } usp_cfg_s;

    typedef struct packed {
        logic      valid;
        usp_byte_t data;
    } usp_char_s;

    typedef struct packed {
        logic      frame_err;
        logic      overrun;
        logic      clk_running;
        logic      tx_busy;
        logic [USP_CNT_W-1:0] fill;
    } usp_status_s;
endpackage : usp_pkg

// *** design/usp_sync.sv ***
`timescale 1ns/10ps
module usp_sync
    import usp_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
)(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // pin
    input  wire logic pin_in,
    output logic      level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } usp_sync_s;

    usp_sync_s st_q;
    usp_sync_s st_d;

    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3)
        begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            st_q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;
endmodule : usp_sync

// *** verif/usp_port_monitor.sv ***
`timescale 1ns/10ps
module usp_port_monitor
    import usp_pkg::*;
(
    // clock and reset
    input wire logic                 clk_in,
    input wire logic                 sys_rst_in,
    // block ports
    input wire usp_pkg::usp_cfg_s    cfg_in,
    input wire usp_pkg::usp_char_s   tx_char_in,
    input wire logic                 tx_ready_out,
    input wire logic                 rx_pop_in,
    input wire usp_pkg::usp_char_s   rx_char_out,
    input wire usp_pkg::usp_status_s status_out,
    input wire logic                 serial_tx_line_out,
    input wire logic                 serial_rx_line_in,
    input wire logic                 send_permit_in,
    input wire logic                 send_request_out
);
    // ****
    // port checks, bit times for divisor 0
    // ****
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    AST_IDLE_MARK: assert property (!status_out.tx_busy && $past(!status_out.tx_busy) |-> serial_tx_line_out)
        else $error("tx line low while idle");
    AST_LOOP_MARK: assert property (cfg_in.loopback |-> serial_tx_line_out)
        else $error("tx line low in loopback");
    AST_BIT_HOLD: assert property ($changed(serial_tx_line_out) |=> $stable(serial_tx_line_out)[*8])
        else $error("tx bit too short");
    AST_START_LOW: assert property ($rose(status_out.tx_busy) |-> ##[1:17] !serial_tx_line_out)
        else $error("no start bit");
    AST_FALL_BUSY: assert property ($fell(serial_tx_line_out) |-> status_out.tx_busy)
        else $error("tx line fell outside a frame");
    AST_TX_TAKE: assert property (tx_char_in.valid && tx_ready_out && !cfg_in.cts_enable |=>
        !tx_ready_out && status_out.tx_busy) else $error("tx char not taken");
    AST_CTS_HOLD: assert property ((cfg_in.cts_enable && !send_permit_in)[*6] |-> !$rose(status_out.tx_busy))
        else $error("tx started without permit");
    AST_WAKE: assert property (cfg_in.power_down && !status_out.clk_running && $changed(serial_rx_line_in)
        |-> ##[1:8] status_out.clk_running) else $error("clock not restarted");
    AST_RTS_FULL: assert property (cfg_in.rts_auto && status_out.fill >= cfg_in.rts_high
        |-> ##[0:2] !send_request_out) else $error("request not negated");
    AST_RTS_LOW: assert property (cfg_in.rts_auto && cfg_in.rx_enable && status_out.fill <= cfg_in.rts_low
        |-> ##[0:2] send_request_out) else $error("request not asserted");
    AST_POP: assert property (rx_char_out.valid |-> $past(rx_pop_in) && $past(status_out.fill) != 4'h0)
        else $error("rx char without pop");
endmodule : usp_port_monitor

bind usp_port usp_port_monitor i_mon (.clk_in, .sys_rst_in, .cfg_in, .tx_char_in, .tx_ready_out, .rx_pop_in,
    .rx_char_out, .status_out, .serial_tx_line_out, .serial_rx_line_in, .send_permit_in, .send_request_out);

// *** verif/usp_partner.sv ***
`timescale 1ns/10ps
module usp_partner
    import usp_pkg::*;
#(
    parameter int BIT_CLKS = 16
)(
    // clock
    input  wire logic clk_in,
    // serial pins, far side
    input  wire logic tx_line_in,
    output logic      rx_line_out,
    output logic      permit_out
);
    logic [8:0] got[$];
    logic [8:0] cur;
    // ****
    // sender and receiver
    // ****
    initial
    begin
        rx_line_out = 1'b1;
        permit_out  = 1'b1;
    end
    // trailing idle bit keeps frames apart
    task automatic send(input usp_pkg::usp_byte_t d, input logic stp);
        logic [10:0] f;
        f = {1'b1, stp, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rx_line_out <= f[i];
            repeat (BIT_CLKS) @(posedge clk_in);
        end
    endtask : send
    task automatic set_permit(input logic v);
        permit_out <= v;
    endtask : set_permit
    always
    begin
        @(negedge tx_line_in);
        repeat (BIT_CLKS / 2) @(posedge clk_in);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT_CLKS) @(posedge clk_in);
            cur[i] = tx_line_in;
        end
        got.push_back(cur);
    end
endmodule : usp_partner

// *** verif/usp_port_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("wrong value %s exp %0h got %0h", n, e, a); end end
`define WAIT(n, c, lim) begin for (int k = 0; k < lim && ((c) !== 1'b1); k++) @(posedge clk_in); \
    if ((c) !== 1'b1) begin err_count++; $display("wrong value wait %s exp 1 got 0", n); test_done(); end end
module usp_port_tb_top;
    import usp_pkg::*;
    logic        clk_in;
    logic        sys_rst_in;
    usp_cfg_s    cfg_in;
    usp_char_s   tx_char_in;
    logic        tx_ready_out;
    logic        rx_pop_in;
    usp_char_s   rx_char_out;
    usp_status_s status_out;
    logic        serial_tx_line_out;
    logic        serial_rx_line_in;
    logic        send_permit_in;
    logic        send_request_out;
    int          err_count;
    int          num_checks;

    usp_port i_dut (.clk_in, .sys_rst_in, .cfg_in, .tx_char_in, .tx_ready_out, .rx_pop_in, .rx_char_out,
        .status_out, .serial_tx_line_out, .serial_rx_line_in, .send_permit_in, .send_request_out);
    usp_partner i_partner (.clk_in, .tx_line_in(serial_tx_line_out), .rx_line_out(serial_rx_line_in),
        .permit_out(send_permit_in));
    // ****
    // helpers
    // ****
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic put_tx(input usp_byte_t d);
        `WAIT("tx ready", tx_ready_out, 400)
        tx_char_in <= '{1'b1, d};
        `WAIT("take", !tx_ready_out, 40)
        tx_char_in.valid <= 1'b0;
    endtask : put_tx
    task automatic pop(input usp_byte_t d);
        rx_pop_in <= 1'b1;
        @(posedge clk_in);
        rx_pop_in <= 1'b0;
        @(posedge clk_in);
        `CHK("rx valid", 1'b1, rx_char_out.valid)
        `CHK("rx data", d, rx_char_out.data)
    endtask : pop
    // ****
    // scenarios
    // ****
    task automatic t_tx();
        put_tx(8'h35);
        put_tx(8'hca);
        `WAIT("frames", i_partner.got.size() == 2, 400)
        `CHK("byte 0", 9'h135, i_partner.got[0])
        `CHK("byte 1", 9'h1ca, i_partner.got[1])
        `CHK("idle line", 1'b1, serial_tx_line_out)
        i_partner.got.delete();
        $display("test tx done");
    endtask : t_tx
    task automatic t_loop();
        logic low = 1'b0;
        cfg_in.loopback <= 1'b1;
        tick(2);
        tx_char_in <= '{1'b1, 8'h00};
        for (int i = 0; i < 300; i++)
        begin
            @(posedge clk_in);
            low |= !serial_tx_line_out;
        end
        `CHK("loop line low", 1'b0, low)
        `CHK("loop ready", 1'b0, tx_ready_out)
        tx_char_in.valid <= 1'b0;
        cfg_in.loopback <= 1'b0;
        tick(2);
        $display("test loopback done");
    endtask : t_loop
    task automatic t_rx();
        `CHK("rts empty", 1'b1, send_request_out)
        for (int i = 0; i < 9; i++)
        begin
            i_partner.send(8'h81 + 8'(i) * 8'h13, 1'b1);
            if (i == 5)
                `CHK("rts full", 1'b0, send_request_out)
        end
        `CHK("fill", 4'h8, status_out.fill)
        `CHK("overrun", 1'b1, status_out.overrun)
        for (int i = 0; i < 8; i++)
            pop(8'h81 + 8'(i) * 8'h13);
        tick(3);
        `CHK("rts drained", 1'b1, send_request_out)
        $display("test rx done");
    endtask : t_rx
    task automatic t_frame();
        i_partner.send(8'h5a, 1'b0);
        tick(4);
        `CHK("frame err", 1'b1, status_out.frame_err)
        `CHK("fill bad stop", 4'h0, status_out.fill)
        $display("test frame done");
    endtask : t_frame
    task automatic t_cts();
        cfg_in.cts_enable <= 1'b1;
        cfg_in.two_stop   <= 1'b1;
        i_partner.set_permit(1'b0);
        tick(6);
        tx_char_in <= '{1'b1, 8'h96};
        tick(300);
        `CHK("held busy", 1'b0, status_out.tx_busy)
        i_partner.set_permit(1'b1);
        `WAIT("take", !tx_ready_out, 40)
        tx_char_in.valid <= 1'b0;
        `WAIT("frame", i_partner.got.size() == 1, 400)
        `CHK("permit byte", 9'h196, i_partner.got[0])
        tick(16);
        `CHK("second stop", 1'b1, status_out.tx_busy)
        tick(16);
        `CHK("stop done", 1'b0, status_out.tx_busy)
        cfg_in.cts_enable <= 1'b0;
        cfg_in.two_stop   <= 1'b0;
        $display("test permit done");
    endtask : t_cts
    task automatic t_wake();
        cfg_in.power_down <= 1'b1;
        `WAIT("clock off", !status_out.clk_running, 200)
        fork
            i_partner.send(8'h55, 1'b1);
            begin
                tick(8);
                `CHK("clock on", 1'b1, status_out.clk_running)
            end
        join
        pop(8'h55);
        cfg_in.power_down <= 1'b0;
        $display("test wake done");
    endtask : t_wake
    task automatic t_rts_man();
        cfg_in.rts_auto <= 1'b0;
        tick(3);
        `CHK("rts manual off", 1'b0, send_request_out)
        cfg_in.rts_manual <= 1'b1;
        tick(3);
        `CHK("rts manual on", 1'b1, send_request_out)
        cfg_in.rts_manual <= 1'b0;
        cfg_in.rts_auto   <= 1'b1;
        tick(3);
        $display("test rts manual done");
    endtask : t_rts_man
    // ****
    // clock and main sequence
    // ****
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial
    begin
        err_count  = 0;
        num_checks = 0;
        sys_rst_in = 1'b1;
        rx_pop_in  = 1'b0;
        tx_char_in = '0;
        cfg_in     = '{tx_enable: 1'b1, rx_enable: 1'b1, rts_auto: 1'b1, rts_high: USP_RTS_HIGH_RESET,
                       rts_low: USP_RTS_LOW_RESET, default: '0};
        tick(5);
        `CHK("reset line", 1'b1, serial_tx_line_out)
        sys_rst_in <= 1'b0;
        tick(2);
        t_tx();
        t_loop();
        t_rx();
        t_frame();
        t_cts();
        t_wake();
        t_rts_man();
        test_done();
    end
endmodule : usp_port_tb_top
